//--- hdl/mcs_pkg.sv
package mcs_pkg;
  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_MISC_OPTION_CONTROL = 8'hed;
  localparam logic [7:0] CMD_CONFIG_SOURCE_SELECT = 8'hee;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // ==========================================================
  // misc option control fields
  localparam int MISC_PEC_BIT = 15;
  localparam int MISC_SHDN_REVERT_BIT = 14;
  localparam int MISC_FLT_REVERT_BIT = 13;
  localparam int MISC_PIN_FUNC_BIT = 12;
  localparam int MISC_PULLUP_N_BIT = 3;
  localparam int MISC_FLT_MODE_BIT = 2;
  localparam int MISC_ADC_LSB = 0;
  // ==========================================================
  // config source select fields
  localparam int SRC_STACK_BIT = 12;
  localparam int SRC_SYNC_BIT = 11;
  localparam int SRC_COMP_BIT = 9;
  localparam int SRC_ADDR_BIT = 8;
  localparam int SRC_PHASE_BIT = 5;
  localparam int SRC_RISE_BIT = 3;
  localparam int SRC_OC_BIT = 2;
  localparam int SRC_FREQUENCY_SOURCE_BIT_BIT = 1;
  localparam int SRC_OUTPUT_VOLTAGE_SOURCE_BIT_BIT = 0;
  // ==========================================================
  // adc widths
  localparam logic [3:0] ADC_W_00 = 4'hc;
  localparam logic [3:0] ADC_W_01 = 4'ha;
  localparam logic [3:0] ADC_W_10 = 4'h8;
  localparam logic [3:0] ADC_W_11 = 4'h6;
  // ==========================================================
  // strap vector layout
  localparam int STP_VCMD = 0;
  localparam int STP_VSCL = 16;
  localparam int STP_VMAX = 32;
  localparam int STP_VMIN = 48;
  localparam int STP_FREQUENCY_SOURCE_BIT = 64;
  localparam int STP_OCW = 80;
  localparam int STP_OCF = 96;
  localparam int STP_RISE = 112;
  localparam int STP_PHASE = 128;
  localparam int STP_ADDR = 136;
  localparam int STP_COMP = 143;
  localparam int STP_SYNC = 151;
  localparam int STP_STACK = 159;
  localparam int STRAP_W = 163;
  localparam int FCNT_W = 4;
endpackage

//--- hdl/mcs_strap_latch.sv
`timescale 1ns/100ps
module mcs_strap_latch
  import mcs_pkg::*;
#(
  parameter int W = STRAP_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // strap pins
  input wire logic [W-1:0] strap_pins,
  // captured value
  output logic [W-1:0] strap_val,
  output logic strap_done
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [1:0] wait_r;
  logic done_r;
  logic cap;

  // ==========================================================
  // capture once after release, never again
  assign cap = (wait_r == 2'h2) && !done_r; // [R10]

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
      wait_r <= 2'h0;
      done_r <= 1'b0;
      strap_val <= '0;
      strap_done <= 1'b0;
    end else begin
      meta_r <= strap_pins;
      sync_r <= meta_r;
      if (wait_r != 2'h2) begin
        wait_r <= wait_r + 2'h1;
      end
      if (cap) begin
        done_r <= 1'b1;
        strap_val <= sync_r; // [R10]
      end
      strap_done <= cap;
    end
  end
endmodule

//--- hdl/mcs_fault_counter.sv
`timescale 1ns/100ps
module mcs_fault_counter
  import mcs_pkg::*;
#(
  parameter int W = FCNT_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // cycle events
  input wire logic pwm_tick,
  input wire logic fault_seen,
  input wire logic clear_mode,
  // count
  output logic [W-1:0] count
);
  logic [W-1:0] count_nxt;
  logic at_max;

  assign at_max = &count;

  // ==========================================================
  // clean cycle steps down one or clears
  always_comb begin
    count_nxt = count;
    if (pwm_tick && fault_seen && !at_max) begin
      count_nxt = count + W'(1);
    end else if (pwm_tick && !fault_seen) begin
      if (clear_mode) begin
        count_nxt = '0; // [R7]
      end else if (count != '0) begin
        count_nxt = count - W'(1); // [R7]
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= count_nxt;
    end
  end
endmodule

//--- hdl/mcs_config_top.sv
`timescale 1ns/100ps
// Contract
// R1 - with checksum bit set, transactions lacking checksum byte are rejected
// R2 - shutdown-revert bit reloads setpoint with boot value after shutdown
// R3 - fault-revert bit with retry reloads setpoint with boot value
// R4 - pin-function bit selects power-good or active-low reset role
// R5 - in reset role bit 3 low enables pullup, high disables it
// R6 - host writes zeros to reserved misc option bits
// R7 - clean switching cycle decrements fault counter, or clears when bit 2
// R8 - adc field selects 12, 10, 8 or 6 bit conversions
// R9 - override bit set keeps pin-programmed value over stored value
// R10 - straps sampled only at power-on, override writes never resample
// R11 - bit 12 selects stored or strap stacking configuration at load
// R12 - bit 11 selects stored or strap sync configuration at load
// R13 - bit 9 selects stored or strap compensation at load
// R14 - bit 8 selects stored or strap bus address at load
// R15 - bit 5 selects stored or strap phase phase_setting_a at load
// R16 - bit 3 selects stored or strap soft-start rise time at load
// R17 - bit 2 selects stored or strap overcurrent limits at load
// R18 - bit 1 selects stored or strap switching frequency at load
// R19 - bit 0 selects stored or strap voltage group at load
// R20 - host keeps unused override bits 15-13 and 7-6 at zero
module mcs_config_top
  import mcs_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // word transactions from the bus engine
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_has_pec,
  input wire logic cmd_pec_ok,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic rsp_pec_err,
  output logic rsp_unsup,
  // stored values
  input wire logic [15:0] nvm_misc,
  input wire logic [15:0] nvm_src,
  input wire logic [3:0] nvm_stack,
  input wire logic [7:0] nvm_sync,
  input wire logic [7:0] nvm_comp,
  input wire logic [6:0] nvm_addr,
  input wire logic [7:0] nvm_phase,
  input wire logic [15:0] nvm_rise,
  input wire logic [15:0] nvm_ocf,
  input wire logic [15:0] nvm_ocw,
  input wire logic [15:0] nvm_frequency_source_bit,
  input wire logic [15:0] nvm_vcmd,
  input wire logic [15:0] nvm_vscl,
  input wire logic [15:0] nvm_vmax,
  input wire logic [15:0] nvm_vmin,
  input wire logic restore_req,
  // strap pins
  input wire logic [STRAP_W-1:0] strap_pins,
  // setpoint control
  input wire logic [15:0] boot_voltage_value,
  input wire logic output_voltage_source_bit_cmd_wr,
  input wire logic [15:0] output_voltage_source_bit_cmd_wdata,
  input wire logic shutdown_event,
  input wire logic fault_restart,
  input wire logic fault_retry_mode,
  // fault counter events
  input wire logic pwm_tick,
  input wire logic fault_seen,
  // status pin sources
  input wire logic power_good_in,
  input wire logic reset_assert,
  // active configuration
  output logic [3:0] stack_cfg,
  output logic [7:0] sync_cfg,
  output logic [7:0] comp_cfg,
  output logic [6:0] bus_addr,
  output logic [7:0] phase_setting_a,
  output logic [15:0] rise_time,
  output logic [15:0] oc_fault_limit,
  output logic [15:0] oc_warn_limit,
  output logic [15:0] switch_frequency_source_bit,
  output logic [15:0] output_voltage_source_bit_command,
  output logic [15:0] output_voltage_source_bit_scale,
  output logic [15:0] output_voltage_source_bit_max,
  output logic [15:0] output_voltage_source_bit_min,
  // misc outputs
  output logic [3:0] adc_width,
  output logic [FCNT_W-1:0] fault_count,
  output logic config_loaded,
  // shared status pin
  output logic shared_status_pin_o,
  output logic shared_status_pin_oe_n,
  output logic shared_status_pin_pullup
);
  logic [15:0] misc_r;
  logic [15:0] src_r;
  logic [STRAP_W-1:0] strap_val;
  logic strap_done;
  logic [FCNT_W-1:0] fcnt;
  logic hit_misc;
  logic hit_src;
  logic pec_bad;
  logic wr_ok;
  logic load;
  logic [15:0] load_src;
  logic [15:0] load_misc;
  logic revert;
  logic fault_count_recovery_mode;
  logic pg_mode;

  // ==========================================================
  // functions
  function automatic logic [3:0] adc_bits(input logic [1:0] sel);
    unique case (sel)
      2'h0: adc_bits = ADC_W_00;
      2'h1: adc_bits = ADC_W_01;
      2'h2: adc_bits = ADC_W_10;
      2'h3: adc_bits = ADC_W_11;
    endcase
  endfunction

  function automatic logic [15:0] pick16(input logic strap,
      input logic [15:0] nvm, input logic [15:0] pin);
    pick16 = strap ? pin : nvm;
  endfunction

  // ==========================================================
  // strap capture and fault counter
  mcs_strap_latch #(.W(STRAP_W)) u_strap (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .strap_pins(strap_pins),
    .strap_val(strap_val),
    .strap_done(strap_done)
  );

  assign fault_count_recovery_mode = misc_r[MISC_FLT_MODE_BIT];

  mcs_fault_counter #(.W(FCNT_W)) u_fcnt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pwm_tick(pwm_tick),
    .fault_seen(fault_seen),
    .clear_mode(fault_count_recovery_mode), // [R7]
    .count(fcnt)
  );

  // ==========================================================
  // transaction decode
  assign hit_misc = cmd_code == CMD_MISC_OPTION_CONTROL;
  assign hit_src = cmd_code == CMD_CONFIG_SOURCE_SELECT;
  assign pec_bad = (cmd_has_pec && !cmd_pec_ok)
                 || (!cmd_has_pec && misc_r[MISC_PEC_BIT]); // [R1]
  assign wr_ok = cmd_valid && cmd_write && !pec_bad;

  // ==========================================================
  // load events: power-up uses stored source, restore the live one
  assign load = strap_done || (restore_req && config_loaded);
  assign load_src = strap_done ? nvm_src : src_r; // [R10]
  assign load_misc = nvm_misc;
  assign revert = (shutdown_event && misc_r[MISC_SHDN_REVERT_BIT]) // [R2]
                || (fault_restart && fault_retry_mode
                    && misc_r[MISC_FLT_REVERT_BIT]); // [R3]
  assign pg_mode = !misc_r[MISC_PIN_FUNC_BIT];

  // ==========================================================
  // option registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      misc_r <= REG_RESET;
      src_r <= REG_RESET;
      config_loaded <= 1'b0;
    end else begin
      if (strap_done) begin
        config_loaded <= 1'b1;
      end
      if (load) begin
        misc_r <= load_misc;
        src_r <= load_src;
      end else if (wr_ok && hit_misc) begin
        misc_r <= cmd_wdata;
      end else if (wr_ok && hit_src) begin
        src_r <= cmd_wdata; // [R10]
      end
    end
  end

  // ==========================================================
  // bus answer, one cycle after the request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
      rsp_pec_err <= 1'b0;
      rsp_unsup <= 1'b0;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_pec_err <= cmd_valid && pec_bad; // [R1]
      rsp_unsup <= cmd_valid && !hit_misc && !hit_src;
      if (cmd_valid && !cmd_write && hit_misc) begin
        rsp_rdata <= misc_r;
      end else if (cmd_valid && !cmd_write && hit_src) begin
        rsp_rdata <= src_r;
      end else begin
        rsp_rdata <= 16'h0000;
      end
    end
  end

  // ==========================================================
  // active configuration, stored or strap per group
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stack_cfg <= 4'h0;
      sync_cfg <= 8'h00;
      comp_cfg <= 8'h00;
      bus_addr <= 7'h00;
      phase_setting_a <= 8'h00;
      rise_time <= 16'h0000;
      oc_fault_limit <= 16'h0000;
      oc_warn_limit <= 16'h0000;
      switch_frequency_source_bit <= 16'h0000;
      output_voltage_source_bit_scale <= 16'h0000;
      output_voltage_source_bit_max <= 16'h0000;
      output_voltage_source_bit_min <= 16'h0000;
    end else if (load) begin
      // [R9]
      stack_cfg <= load_src[SRC_STACK_BIT]
                 ? strap_val[STP_STACK +: 4] : nvm_stack; // [R11]
      sync_cfg <= load_src[SRC_SYNC_BIT]
                ? strap_val[STP_SYNC +: 8] : nvm_sync; // [R12]
      comp_cfg <= load_src[SRC_COMP_BIT]
                ? strap_val[STP_COMP +: 8] : nvm_comp; // [R13]
      bus_addr <= load_src[SRC_ADDR_BIT]
                ? strap_val[STP_ADDR +: 7] : nvm_addr; // [R14]
      phase_setting_a <= load_src[SRC_PHASE_BIT]
                       ? strap_val[STP_PHASE +: 8] : nvm_phase; // [R15]
      rise_time <= pick16(load_src[SRC_RISE_BIT], nvm_rise,
                          strap_val[STP_RISE +: 16]); // [R16]
      oc_fault_limit <= pick16(load_src[SRC_OC_BIT], nvm_ocf,
                               strap_val[STP_OCF +: 16]); // [R17]
      oc_warn_limit <= pick16(load_src[SRC_OC_BIT], nvm_ocw,
                              strap_val[STP_OCW +: 16]); // [R17]
      switch_frequency_source_bit <= pick16(load_src[SRC_FREQUENCY_SOURCE_BIT_BIT], nvm_frequency_source_bit,
                            strap_val[STP_FREQUENCY_SOURCE_BIT +: 16]); // [R18]
      output_voltage_source_bit_scale <= pick16(load_src[SRC_OUTPUT_VOLTAGE_SOURCE_BIT_BIT], nvm_vscl,
                           strap_val[STP_VSCL +: 16]); // [R19]
      output_voltage_source_bit_max <= pick16(load_src[SRC_OUTPUT_VOLTAGE_SOURCE_BIT_BIT], nvm_vmax,
                         strap_val[STP_VMAX +: 16]); // [R19]
      output_voltage_source_bit_min <= pick16(load_src[SRC_OUTPUT_VOLTAGE_SOURCE_BIT_BIT], nvm_vmin,
                         strap_val[STP_VMIN +: 16]); // [R19]
    end
  end

  // ==========================================================
  // output setpoint: load, then revert, then host write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      output_voltage_source_bit_command <= 16'h0000;
    end else if (load) begin
      output_voltage_source_bit_command <= pick16(load_src[SRC_OUTPUT_VOLTAGE_SOURCE_BIT_BIT], nvm_vcmd,
                             strap_val[STP_VCMD +: 16]); // [R19]
    end else if (revert) begin
      output_voltage_source_bit_command <= boot_voltage_value; // [R2] [R3]
    end else if (output_voltage_source_bit_cmd_wr) begin
      output_voltage_source_bit_command <= output_voltage_source_bit_cmd_wdata;
    end
  end

  // ==========================================================
  // telemetry width, counter, status pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      adc_width <= ADC_W_00;
      fault_count <= '0;
      shared_status_pin_o <= 1'b0;
      shared_status_pin_oe_n <= 1'b1;
      shared_status_pin_pullup <= 1'b0;
    end else begin
      adc_width <= adc_bits(misc_r[MISC_ADC_LSB +: 2]); // [R8]
      fault_count <= fcnt;
      shared_status_pin_o <= 1'b0;
      // open drain: pull low when not good, or when reset asserted
      shared_status_pin_oe_n <= pg_mode ? power_good_in
                                        : !reset_assert; // [R4]
      shared_status_pin_pullup <= !pg_mode
                                  && !misc_r[MISC_PULLUP_N_BIT]; // [R4] [R5]
    end
  end

  // ==========================================================
  // checks
  a_pec_reject: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_valid && !cmd_has_pec && misc_r[MISC_PEC_BIT] && !load
    |=> rsp_pec_err && $stable(misc_r)) // [R1]
    else $error("missing checksum not rejected");
  a_pec_optional: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_valid && cmd_write && hit_misc && !cmd_has_pec
    && !misc_r[MISC_PEC_BIT] && !load |=> !rsp_pec_err
    && misc_r == $past(cmd_wdata)) // [R1]
    else $error("optional checksum write lost");
  a_shdn_revert: assert property (@(posedge clk_sys) disable iff (!rst_n)
    shutdown_event && misc_r[MISC_SHDN_REVERT_BIT] && !load
    |=> output_voltage_source_bit_command == $past(boot_voltage_value)) // [R2]
    else $error("setpoint not reverted after shutdown");
  a_no_revert: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !load && !output_voltage_source_bit_cmd_wr && !revert |=> $stable(output_voltage_source_bit_command)) // [R3]
    else $error("setpoint changed without cause");
  a_pin_role: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !misc_r[MISC_PIN_FUNC_BIT] && $stable(misc_r)
    |=> !shared_status_pin_pullup
    && shared_status_pin_oe_n == $past(power_good_in)) // [R4]
    else $error("power good role wrong");
  a_pullup_ctl: assert property (@(posedge clk_sys) disable iff (!rst_n)
    misc_r[MISC_PIN_FUNC_BIT] ##1 $stable(misc_r)
    |-> shared_status_pin_pullup == !$past(misc_r[MISC_PULLUP_N_BIT])) // [R5]
    else $error("pullup control wrong");
  a_clean_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pwm_tick && !fault_seen && fault_count_recovery_mode
    |=> fcnt == '0 ##1 fault_count == '0) // [R7]
    else $error("fault counter not cleared");
  a_adc_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
    misc_r[1:0] == 2'h2 && $stable(misc_r) |=> adc_width == ADC_W_10) // [R8]
    else $error("adc width wrong");
  a_strap_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
    config_loaded |-> !strap_done) // [R10]
    else $error("straps sampled twice");
  a_addr_strap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load && load_src[SRC_ADDR_BIT]
    |=> bus_addr == $past(strap_val[STP_ADDR +: 7])) // [R9] [R14]
    else $error("strap address overwritten");
  a_frequency_source_bit_nvm: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load && !load_src[SRC_FREQUENCY_SOURCE_BIT_BIT] |=> switch_frequency_source_bit == $past(nvm_frequency_source_bit)) // [R18]
    else $error("stored frequency not loaded");
endmodule

//--- test/mcs_host_model.sv
`timescale 1ns/100ps
module mcs_host_model
  import mcs_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // request
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  output logic cmd_has_pec,
  output logic cmd_pec_ok,
  // answer
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic rsp_pec_err,
  input wire logic rsp_unsup
);
  // ==========================================================
  // reserved fields always written as zero
  localparam logic [15:0] MISC_KEEP = 16'hf00f;
  localparam logic [15:0] SRC_KEEP = 16'h1f3f;

  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    cmd_has_pec = 1'b0;
    cmd_pec_ok = 1'b0;
  end

  // ==========================================================
  // one word transaction, started just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] code,
                      input logic [15:0] data, input logic pec,
                      output logic [2:0] flags, output logic [15:0] rd);
    logic [15:0] d;
    d = data;
    if (wr && code == CMD_MISC_OPTION_CONTROL) begin
      d = data & MISC_KEEP;
    end
    if (wr && code == CMD_CONFIG_SOURCE_SELECT) begin
      d = data & SRC_KEEP;
    end
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = d;
    cmd_has_pec = pec;
    cmd_pec_ok = pec;
    @(posedge clk_sys);
    #1;
    flags = {rsp_valid, rsp_pec_err, rsp_unsup};
    rd = rsp_rdata;
    // released lines no longer show the last value
    cmd_valid = 1'b0;
    cmd_write = ~wr;
    cmd_code = ~code;
    cmd_wdata = ~d;
    cmd_has_pec = ~pec;
    cmd_pec_ok = ~pec;
    @(posedge clk_sys);
    #1;
  endtask
endmodule

//--- test/misc_options_and_config_source_test.sv
`timescale 1ns/100ps
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); \
  end \
end
module misc_options_and_config_source_test
  import mcs_pkg::*;
;
  // ==========================================================
  // signals
  localparam logic [STRAP_W-1:0] STRAP_A = STRAP_W'({24{7'h5a}});
  localparam logic [15:0] ADC_EXP = {ADC_W_11, ADC_W_10, ADC_W_01,
                                     ADC_W_00};
  localparam logic [7:0] MISC = CMD_MISC_OPTION_CONTROL;
  localparam logic [7:0] SRC = CMD_CONFIG_SOURCE_SELECT;
  int failures = 0;
  int compares = 0;
  logic clk_sys, rst_n, cmd_valid, cmd_write, cmd_has_pec, cmd_pec_ok;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rsp_rdata, rd;
  logic rsp_valid, rsp_pec_err, rsp_unsup, config_loaded;
  logic [15:0] nvm_misc, nvm_src, nvm_rise, nvm_ocf, nvm_ocw, nvm_frequency_source_bit;
  logic [15:0] nvm_vcmd, nvm_vscl, nvm_vmax, nvm_vmin;
  logic [3:0] nvm_stack, stack_cfg, adc_width;
  logic [7:0] nvm_sync, nvm_comp, nvm_phase;
  logic [7:0] sync_cfg, comp_cfg, phase_setting_a;
  logic [6:0] nvm_addr, bus_addr;
  logic restore_req, output_voltage_source_bit_cmd_wr, shutdown_event, fault_restart;
  logic fault_retry_mode, pwm_tick, fault_seen, power_good_in;
  logic reset_assert;
  logic [15:0] boot_voltage_value, output_voltage_source_bit_cmd_wdata;
  logic [STRAP_W-1:0] strap_pins;
  logic [15:0] rise_time, oc_fault_limit, oc_warn_limit, switch_frequency_source_bit;
  logic [15:0] output_voltage_source_bit_command, output_voltage_source_bit_scale, output_voltage_source_bit_max, output_voltage_source_bit_min;
  logic [FCNT_W-1:0] fault_count;
  logic shared_status_pin_o, shared_status_pin_oe_n;
  logic shared_status_pin_pullup;

  mcs_config_top dut (.clk_sys, .rst_n, .cmd_valid, .cmd_write, .cmd_code,
    .cmd_wdata, .cmd_has_pec, .cmd_pec_ok, .rsp_valid, .rsp_rdata,
    .rsp_pec_err, .rsp_unsup, .nvm_misc, .nvm_src, .nvm_stack, .nvm_sync,
    .nvm_comp, .nvm_addr, .nvm_phase, .nvm_rise, .nvm_ocf, .nvm_ocw,
    .nvm_frequency_source_bit, .nvm_vcmd, .nvm_vscl, .nvm_vmax, .nvm_vmin, .restore_req,
    .strap_pins, .boot_voltage_value, .output_voltage_source_bit_cmd_wr, .output_voltage_source_bit_cmd_wdata,
    .shutdown_event, .fault_restart, .fault_retry_mode, .pwm_tick,
    .fault_seen, .power_good_in, .reset_assert, .stack_cfg, .sync_cfg,
    .comp_cfg, .bus_addr, .phase_setting_a, .rise_time, .oc_fault_limit,
    .oc_warn_limit, .switch_frequency_source_bit, .output_voltage_source_bit_command, .output_voltage_source_bit_scale, .output_voltage_source_bit_max,
    .output_voltage_source_bit_min, .adc_width, .fault_count, .config_loaded,
    .shared_status_pin_o, .shared_status_pin_oe_n,
    .shared_status_pin_pullup);

  mcs_host_model host (.clk_sys, .cmd_valid, .cmd_write, .cmd_code,
    .cmd_wdata, .cmd_has_pec, .cmd_pec_ok, .rsp_valid, .rsp_rdata,
    .rsp_pec_err, .rsp_unsup);

  // ==========================================================
  // helpers
  task tick;
    @(posedge clk_sys);
    #1;
  endtask

  task bus(input logic wr, input logic [7:0] c, input logic [15:0] d,
           input logic pec, input logic [2:0] ef);
    logic [2:0] fl;
    host.xfer(wr, c, d, pec, fl, rd);
    `CHK(fl, ef);
  endtask

  task pulse(input int k);
    case (k)
      0: shutdown_event = 1'b1;
      1: fault_restart = 1'b1;
      2: restore_req = 1'b1;
      default: output_voltage_source_bit_cmd_wr = 1'b1;
    endcase
    tick;
    shutdown_event = 1'b0;
    fault_restart = 1'b0;
    restore_req = 1'b0;
    output_voltage_source_bit_cmd_wr = 1'b0;
    tick;
  endtask

  task check_cfg(input logic [15:0] s, input logic [STRAP_W-1:0] p);
    `CHK(stack_cfg, s[SRC_STACK_BIT] ? p[STP_STACK +: 4] : nvm_stack);
    `CHK(sync_cfg, s[SRC_SYNC_BIT] ? p[STP_SYNC +: 8] : nvm_sync);
    `CHK(comp_cfg, s[SRC_COMP_BIT] ? p[STP_COMP +: 8] : nvm_comp);
    `CHK(bus_addr, s[SRC_ADDR_BIT] ? p[STP_ADDR +: 7] : nvm_addr);
    `CHK(phase_setting_a, s[5] ? p[STP_PHASE +: 8] : nvm_phase);
    `CHK(rise_time, s[SRC_RISE_BIT] ? p[STP_RISE +: 16] : nvm_rise);
    `CHK(oc_fault_limit, s[SRC_OC_BIT] ? p[STP_OCF +: 16] : nvm_ocf);
    `CHK(oc_warn_limit, s[SRC_OC_BIT] ? p[STP_OCW +: 16] : nvm_ocw);
    `CHK(switch_frequency_source_bit, s[SRC_FREQUENCY_SOURCE_BIT_BIT] ? p[STP_FREQUENCY_SOURCE_BIT +: 16] : nvm_frequency_source_bit);
    `CHK(output_voltage_source_bit_command, s[0] ? p[STP_VCMD +: 16] : nvm_vcmd);
    `CHK(output_voltage_source_bit_scale, s[0] ? p[STP_VSCL +: 16] : nvm_vscl);
    `CHK(output_voltage_source_bit_max, s[0] ? p[STP_VMAX +: 16] : nvm_vmax);
    `CHK(output_voltage_source_bit_min, s[0] ? p[STP_VMIN +: 16] : nvm_vmin);
  endtask

  // ==========================================================
  // scenarios
  task t_powerup;
    int n;
    n = 0;
    while (config_loaded !== 1'b1 && n < 20) begin
      tick;
      n++;
    end
    `CHK(config_loaded, 1'b1);
    check_cfg(16'h0a25, STRAP_A);
    bus(1'b0, SRC, 16'h0000, 1'b1, 3'b100);
    `CHK(rd, 16'h0a25);
    `CHK(adc_width, ADC_W_10);
  endtask

  task t_adc;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, MISC, 16'(i), 1'b1, 3'b100);
      tick;
      `CHK(adc_width, ADC_EXP[i*4 +: 4]);
      bus(1'b0, MISC, 16'h0000, 1'b1, 3'b100);
      `CHK(rd, 16'(i));
    end
  endtask

  task t_pec;
    bus(1'b1, MISC, 16'h8000, 1'b1, 3'b100);
    bus(1'b1, MISC, 16'h0003, 1'b0, 3'b110);
    bus(1'b0, MISC, 16'h0000, 1'b1, 3'b100);
    `CHK(rd, 16'h8000);
    bus(1'b0, MISC, 16'h0000, 1'b0, 3'b110);
    bus(1'b1, MISC, 16'h0001, 1'b1, 3'b100);
    bus(1'b1, MISC, 16'h0002, 1'b0, 3'b100);
    bus(1'b0, MISC, 16'h0000, 1'b0, 3'b100);
    `CHK(rd, 16'h0002);
    bus(1'b0, 8'hf0, 16'h0000, 1'b1, 3'b101);
  endtask

  task t_restore;
    strap_pins = ~STRAP_A;
    bus(1'b1, SRC, 16'h1116, 1'b1, 3'b100);
    pulse(2);
    check_cfg(16'h1116, STRAP_A);
  endtask

  task t_revert;
    fault_retry_mode = 1'b0;
    bus(1'b1, MISC, 16'h0000, 1'b1, 3'b100);
    output_voltage_source_bit_cmd_wdata = 16'h1234;
    pulse(3);
    pulse(0);
    `CHK(output_voltage_source_bit_command, 16'h1234);
    bus(1'b1, MISC, 16'h4000, 1'b1, 3'b100);
    pulse(0);
    `CHK(output_voltage_source_bit_command, boot_voltage_value);
    output_voltage_source_bit_cmd_wdata = 16'h2345;
    pulse(3);
    bus(1'b1, MISC, 16'h2000, 1'b1, 3'b100);
    pulse(1);
    `CHK(output_voltage_source_bit_command, 16'h2345);
    fault_retry_mode = 1'b1;
    pulse(1);
    `CHK(output_voltage_source_bit_command, boot_voltage_value);
    pulse(3);
    bus(1'b1, MISC, 16'h4000, 1'b1, 3'b100);
    pulse(1);
    `CHK(output_voltage_source_bit_command, 16'h2345);
  endtask

  task t_pin;
    logic [15:0] mv;
    logic b;
    for (int i = 0; i < 3; i++) begin
      mv = (i == 0) ? 16'h0000 : (i == 1) ? 16'h1000 : 16'h1008;
      bus(1'b1, MISC, mv, 1'b1, 3'b100);
      for (int j = 0; j < 2; j++) begin
        b = j[0];
        power_good_in = b;
        reset_assert = b;
        tick;
        tick;
        `CHK(shared_status_pin_oe_n, mv[12] ? ~b : b);
        `CHK(shared_status_pin_pullup, mv[12] & ~mv[3]);
        `CHK(shared_status_pin_o, 1'b0);
      end
    end
  endtask

  task tk(input logic f);
    fault_seen = f;
    pwm_tick = 1'b1;
    tick;
    pwm_tick = 1'b0;
    tick;
    tick;
  endtask

  task t_fcnt;
    bus(1'b1, MISC, 16'h0000, 1'b1, 3'b100);
    for (int i = 0; i < 17; i++) begin
      tk(1'b1);
    end
    `CHK(fault_count, 4'hf);
    tk(1'b0);
    `CHK(fault_count, 4'he);
    bus(1'b1, MISC, 16'h0004, 1'b1, 3'b100);
    tk(1'b0);
    `CHK(fault_count, 4'h0);
  endtask

  // ==========================================================
  // run control
  task finish_test;
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    finish_test;
  end

  initial begin
    rst_n = 1'b0;
    nvm_misc = 16'h0002;
    nvm_src = 16'h0a25;
    nvm_stack = 4'h3;
    nvm_sync = 8'h81;
    nvm_comp = 8'h42;
    nvm_addr = 7'h24;
    nvm_phase = 8'h11;
    nvm_rise = 16'h0102;
    nvm_ocf = 16'h0203;
    nvm_ocw = 16'h0304;
    nvm_frequency_source_bit = 16'h0405;
    nvm_vcmd = 16'h0506;
    nvm_vscl = 16'h0607;
    nvm_vmax = 16'h0708;
    nvm_vmin = 16'h0809;
    strap_pins = STRAP_A;
    boot_voltage_value = 16'h0abc;
    output_voltage_source_bit_cmd_wdata = 16'h0000;
    {restore_req, output_voltage_source_bit_cmd_wr, shutdown_event, fault_restart} = 4'h0;
    {fault_retry_mode, pwm_tick, fault_seen} = 3'h0;
    {power_good_in, reset_assert} = 2'h0;
    repeat (3) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    t_powerup;
    t_adc;
    t_pec;
    t_restore;
    t_revert;
    t_pin;
    t_fcnt;
    finish_test;
  end
endmodule
